// *** rtl/tsp_map.svh ***
// Purpose: Named constants of the thermal sensor two-wire register port
// Assumes: Included by bare name from the port module only
// Notes: Definitions only
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

// Register indices carried by the pointer byte
`define TSP_IDX_CAP 8'h00
`define TSP_IDX_CTL 8'h01
`define TSP_IDX_UPPER 8'h02
`define TSP_IDX_LOWER 8'h03
`define TSP_IDX_CRIT 8'h04
`define TSP_IDX_TEMP 8'h05
`define TSP_IDX_MAKER 8'h06
`define TSP_IDX_PART 8'h07
`define TSP_IDX_RES 8'h08

// Reset values
`define TSP_CAP_RST 16'h004f
`define TSP_CTL_RST 16'h0000
`define TSP_LIMIT_RST 16'h0000
`define TSP_RES_RST 16'h000f
`define TSP_PTR_RST 8'h00

// Field layout
`define TSP_CAP_KEEP 16'h00ff
`define TSP_CTL_KEEP 16'h07ff
`define TSP_CAP_POLICY 7
`define TSP_CTL_HYST_HI 10
`define TSP_CTL_HYST_LO 9
`define TSP_CTL_SLEEP 8
`define TSP_CTL_CLOCK 7
`define TSP_CTL_WLOCK 6
`define TSP_CTL_MODE 0

// Bus address and byte framing
`define TSP_ADDR_FIXED 4'h3
`define TSP_BYTE_LAST 4'h7
`define TSP_BYTE_ACK 4'h8

`endif

// *** rtl/tsp_pkg.sv ***
// Purpose: Types of the thermal sensor two-wire register port
// Assumes: Phase codes are literal; tsp_map.svh is not included here
// Notes: Byte phases are Gray coded along a write and between the two read bytes
package tsp_pkg;
  typedef enum logic [2:0] {
    TSP_IDLE = 3'h0,
    TSP_ADDR = 3'h1,
    TSP_PTR = 3'h3,
    TSP_HI = 3'h2,
    TSP_LO = 3'h6,
    TSP_RD_HI = 3'h7,
    TSP_RD_LO = 3'h5
  } tsp_phase_e;
endpackage

// *** rtl/tsp_port.sv ***
// Purpose: Two-wire slave port and register map of a thermal sensor
// Assumes: scl is the link clock; sda is open drain with pull-up outside
// Notes: Link logic runs on scl edges and the start marker on sda falling, sensor side on ref_clk
//
// Functional notes
// - Answer only address 0011 plus strap bits
// - Three strap pins fill low address bits
// - Bus timeout not implemented, optional here
// - Fully static link logic, any slow clock
// - Accept pointer-only and pointer-plus-word writes
// - Read with stored pointer or repeated start
// - Pointer is write-only, selects later transfers
// - Index 00 read-only capability, reset 004F
// - Index 01 control word, reset 0000
// - Index 08 resolution word, reset 000F
// - Index 07 returns identity and revision
// - Capability upper byte reads zero always
// - Policy zero: alert frozen through shutdown
// - Policy one: alert released during shutdown
// - Capability bit 6 reports timeout window
// - Capability bits 4:3 report resolution
// - Capability bit 2 reports signed range
// - Capability bit 1 reports accuracy grade
// - Capability bit 0 reports interrupt support
// - Control bits 15:11 read zero
// - Control bits 10:9 select hysteresis
// - Either lock bit freezes hysteresis bits
// - Pointer resets to 00, keeps last value
// - Bytes travel most significant bit first
// - Accept ack or nack after read byte
`timescale 1ns/1ns
`default_nettype none
`include "tsp_map.svh"

module tsp_port
  import tsp_pkg::*;
#(
  parameter logic [15:0] CAP_WORD = `TSP_CAP_RST,
  parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_REV = 16'h5601 // Arbitrary value
)
(
  // Sensor side clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Two-wire link
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic strap_bit_high,
  input wire logic strap_bit_mid,
  input wire logic strap_bit_low,
  // Sensor core
  input wire logic [15:0] measured_temp_in,
  input wire logic alert_request,
  input wire logic sample_done,
  output logic sleep_control,
  output logic [1:0] hyst_select,
  output logic [15:0] resolution_word,
  output logic alert_active
);

  // Link side state
  tsp_phase_e state;
  tsp_phase_e next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] next_tx;
  logic [15:0] tx_word;
  logic [7:0] data_hi;
  logic [7:0] register_index;
  logic rw_flag;
  logic start_tog;
  logic start_seen;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [15:0] control_word;
  logic [15:0] upper_threshold;
  logic [15:0] lower_threshold;
  logic [15:0] critical_threshold;
  logic [15:0] resolution_select;
  logic [15:0] temp_link;
  logic [15:0] rd_word;
  logic wr_tog;
  logic temp_ack;
  logic [1:0] temp_req_s;

  // Sensor side state
  logic [15:0] temp_hold;
  logic temp_req;
  logic [1:0] temp_ack_s;
  logic [1:0] wr_tog_s;
  logic wr_seen;
  logic [15:0] ctl_ref;
  logic exit_hold;

  assign sda_out = 1'b0;

  // Start marker: sda falling while scl is high, kept as a toggle so
  // the link clock can pick it up on its next falling edge
  always_ff @(negedge sda_in or posedge sys_rst)
  begin
    if (sys_rst)
      start_tog <= 1'b0;
    else if (scl)
      start_tog <= ~start_tog;
  end

  // Bits and straps are sampled on the rising edge, MSB arrives first
  always_ff @(posedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shreg <= 8'h00;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end
    else
    begin
      shreg <= {shreg[6:0], sda_in};
      strap_s1 <= {strap_bit_high, strap_bit_mid, strap_bit_low};
      strap_s2 <= strap_s1;
    end
  end

  // Byte framing decode
  wire start_now = (start_tog != start_seen);
  wire byte_end = (bit_cnt == `TSP_BYTE_LAST) && !start_now;
  wire ack_end = (bit_cnt == `TSP_BYTE_ACK) && !start_now;
  wire addr_hit = (shreg[7:4] == `TSP_ADDR_FIXED)
    && (shreg[3:1] == strap_s2);
  wire reading = (state == TSP_RD_HI) || (state == TSP_RD_LO);
  wire next_reading = (next_state == TSP_RD_HI)
    || (next_state == TSP_RD_LO);
  wire host_ack = ~shreg[0];
  wire ptr_wr = (state == TSP_PTR) && byte_end;
  wire hi_wr = (state == TSP_HI) && byte_end;
  wire reg_wr = (state == TSP_LO) && byte_end;
  wire [15:0] wdata = {data_hi, shreg};
  wire ack_drive = byte_end
    && (((state == TSP_ADDR) && addr_hit) || (state == TSP_PTR)
    || (state == TSP_HI) || (state == TSP_LO));
  wire tx_drive = next_reading && !byte_end && !start_now;
  wire hyst_locked = control_word[`TSP_CTL_CLOCK]
    || control_word[`TSP_CTL_WLOCK];
  wire [15:0] ctl_masked = wdata & `TSP_CTL_KEEP;
  wire [1:0] next_hyst = hyst_locked
    ? control_word[`TSP_CTL_HYST_HI:`TSP_CTL_HYST_LO]
    : ctl_masked[`TSP_CTL_HYST_HI:`TSP_CTL_HYST_LO];
  wire [15:0] next_ctl = {ctl_masked[15:11], next_hyst, ctl_masked[8:0]};

  // Byte phase sequencing; a start always wins over the current phase
  always_comb
  begin
    next_state = state;
    if (start_now)
      next_state = TSP_ADDR;
    else
      case (state)
        TSP_ADDR:
          if (byte_end && !addr_hit)
            next_state = TSP_IDLE;
          else if (ack_end)
            next_state = rw_flag ? TSP_RD_HI : TSP_PTR;
        TSP_PTR:
          if (ack_end)
            next_state = TSP_HI;
        TSP_HI:
          if (ack_end)
            next_state = TSP_LO;
        TSP_LO:
          if (ack_end)
            next_state = TSP_IDLE;
        TSP_RD_HI:
          if (ack_end)
            next_state = host_ack ? TSP_RD_LO : TSP_IDLE;
        TSP_RD_LO:
          if (ack_end)
            next_state = host_ack ? TSP_RD_HI : TSP_IDLE;
        default:
          next_state = TSP_IDLE;
      endcase
  end

  // Transmit byte: reload at each read byte, else shift out MSB first
  always_comb
  begin
    if (ack_end && (next_state == TSP_RD_HI))
      next_tx = rd_word[15:8];
    else if (ack_end && (next_state == TSP_RD_LO))
      next_tx = tx_word[7:0];
    else if (reading && !ack_end)
      next_tx = {txreg[6:0], 1'b0};
    else
      next_tx = txreg;
  end

  // Read selection by the stored pointer
  always_comb
  begin
    case (register_index)
      `TSP_IDX_CAP: rd_word = CAP_WORD & `TSP_CAP_KEEP;
      `TSP_IDX_CTL: rd_word = control_word;
      `TSP_IDX_UPPER: rd_word = upper_threshold;
      `TSP_IDX_LOWER: rd_word = lower_threshold;
      `TSP_IDX_CRIT: rd_word = critical_threshold;
      `TSP_IDX_TEMP: rd_word = temp_link;
      `TSP_IDX_MAKER: rd_word = MAKER_CODE;
      `TSP_IDX_PART: rd_word = PART_REV;
      `TSP_IDX_RES: rd_word = resolution_select;
      default: rd_word = 16'h0000;
    endcase
  end

  // Framing registers; the whole link side is static, so any slow scl
  // works and no bus timeout is kept
  always_ff @(negedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= TSP_IDLE;
      bit_cnt <= 4'h0;
      start_seen <= 1'b0;
      sda_oe <= 1'b0;
      txreg <= 8'h00;
      rw_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= (start_now || ack_end) ? 4'h0 : bit_cnt + 4'h1;
      start_seen <= start_tog;
      sda_oe <= tx_drive ? ~next_tx[7] : ack_drive;
      txreg <= next_tx;
      if ((state == TSP_ADDR) && byte_end)
        rw_flag <= shreg[0];
    end
  end

  // Register file, written at the end of the second data byte
  always_ff @(negedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      register_index <= `TSP_PTR_RST;
      data_hi <= 8'h00;
      tx_word <= 16'h0000;
      control_word <= `TSP_CTL_RST;
      upper_threshold <= `TSP_LIMIT_RST;
      lower_threshold <= `TSP_LIMIT_RST;
      critical_threshold <= `TSP_LIMIT_RST;
      resolution_select <= `TSP_RES_RST;
      wr_tog <= 1'b0;
    end
    else
    begin
      if (ptr_wr)
        register_index <= shreg;
      if (hi_wr)
        data_hi <= shreg;
      if (ack_end && (next_state == TSP_RD_HI))
        tx_word <= rd_word; // Low byte comes from the same word
      if (reg_wr)
        wr_tog <= ~wr_tog;
      if (reg_wr && (register_index == `TSP_IDX_CTL))
        control_word <= next_ctl;
      if (reg_wr && (register_index == `TSP_IDX_UPPER))
        upper_threshold <= wdata;
      if (reg_wr && (register_index == `TSP_IDX_LOWER))
        lower_threshold <= wdata;
      if (reg_wr && (register_index == `TSP_IDX_CRIT))
        critical_threshold <= wdata;
      if (reg_wr && (register_index == `TSP_IDX_RES))
        resolution_select <= wdata;
    end
  end

  // Temperature crossing, link half: the word only moves while scl runs,
  // which is fine since it is only read while scl runs
  always_ff @(negedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      temp_req_s <= 2'b00;
      temp_ack <= 1'b0;
      temp_link <= 16'h0000;
    end
    else
    begin
      temp_req_s <= {temp_req_s[0], temp_req};
      if (temp_req_s[1] != temp_ack)
      begin
        temp_link <= temp_hold;
        temp_ack <= temp_req_s[1];
      end
    end
  end

  // Temperature crossing, sensor half: hold stays still until taken
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      temp_ack_s <= 2'b00;
      temp_req <= 1'b0;
      temp_hold <= 16'h0000;
    end
    else
    begin
      temp_ack_s <= {temp_ack_s[0], temp_ack};
      if (temp_ack_s[1] == temp_req)
      begin
        temp_hold <= measured_temp_in;
        temp_req <= ~temp_req;
      end
    end
  end

  // Written words cross on a toggle; a write frame lasts many ref_clk
  // cycles, so the words are steady when the sensor side copies them
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_tog_s <= 2'b00;
      wr_seen <= 1'b0;
      ctl_ref <= `TSP_CTL_RST;
      resolution_word <= `TSP_RES_RST;
    end
    else
    begin
      wr_tog_s <= {wr_tog_s[0], wr_tog};
      wr_seen <= wr_tog_s[1];
      if (wr_tog_s[1] != wr_seen)
      begin
        ctl_ref <= control_word;
        resolution_word <= resolution_select;
      end
    end
  end

  assign sleep_control = ctl_ref[`TSP_CTL_SLEEP];
  assign hyst_select = ctl_ref[`TSP_CTL_HYST_HI:`TSP_CTL_HYST_LO];
  wire policy_release = CAP_WORD[`TSP_CAP_POLICY];
  wire comparator_mode = ~ctl_ref[`TSP_CTL_MODE];

  // Alert across shutdown: freeze or release, then wait for a sample unless in comparator mode
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      alert_active <= 1'b0;
      exit_hold <= 1'b0;
    end
    else if (sleep_control)
    begin
      exit_hold <= 1'b1;
      if (policy_release)
        alert_active <= 1'b0;
    end
    else if (exit_hold && !sample_done && !comparator_mode)
      exit_hold <= 1'b1;
    else
    begin
      exit_hold <= 1'b0;
      alert_active <= alert_request;
    end
  end

  // Link checks
  a_ack_on_match: assert property (@(negedge scl) disable iff (sys_rst)
    (state == TSP_ADDR && byte_end && addr_hit) |=> sda_oe)
    else $error("matching address not acknowledged");
  a_no_foreign_ack: assert property (@(negedge scl) disable iff (sys_rst)
    (state == TSP_ADDR && byte_end && !addr_hit)
    |=> (!sda_oe && state == TSP_IDLE))
    else $error("foreign address acknowledged");
  a_pointer_load: assert property (@(negedge scl) disable iff (sys_rst)
    ptr_wr |=> (register_index == $past(shreg)))
    else $error("pointer byte not stored");
  a_hyst_lock: assert property (@(negedge scl) disable iff (sys_rst)
    (reg_wr && register_index == `TSP_IDX_CTL && hyst_locked)
    |=> $stable(control_word[10:9]))
    else $error("locked hysteresis changed");
  a_ctl_reserved: assert property (@(negedge scl) disable iff (sys_rst)
    (reg_wr && register_index == `TSP_IDX_CTL)
    |=> (control_word[15:11] == 5'h00))
    else $error("reserved control bits set");
  a_cap_value: assert property (@(negedge scl) disable iff (sys_rst)
    (register_index == `TSP_IDX_CAP) |-> (rd_word[15:8] == 8'h00))
    else $error("capability upper byte not zero");
  a_read_load: assert property (@(negedge scl) disable iff (sys_rst)
    (state == TSP_ADDR && ack_end && rw_flag)
    |=> (txreg == $past(rd_word[15:8])) ##1 (txreg[7] == $past(txreg[6])))
    else $error("read word not loaded msb first");
  a_nack_ends: assert property (@(negedge scl) disable iff (sys_rst)
    (reading && ack_end && !host_ack) |=> (state == TSP_IDLE && !sda_oe))
    else $error("nack did not end the read");
  a_word_write: assert property (@(negedge scl) disable iff (sys_rst)
    (reg_wr && register_index == `TSP_IDX_RES)
    |=> (resolution_select == {$past(data_hi), $past(shreg)}))
    else $error("resolution word not written");

  // Sensor side check
  a_sleep_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sleep_control && policy_release) |=> !alert_active)
    else $error("alert driven in shutdown");

  // Main scenarios
  c_addr_ack: cover property (@(negedge scl) disable iff (sys_rst)
    state == TSP_ADDR && byte_end && addr_hit);
  c_read_nack: cover property (@(negedge scl) disable iff (sys_rst)
    reading && ack_end && !host_ack);
  c_ctl_write: cover property (@(negedge scl) disable iff (sys_rst)
    reg_wr && register_index == `TSP_IDX_CTL);
  c_repeat_start: cover property (@(negedge scl) disable iff (sys_rst)
    state == TSP_HI && start_now);

endmodule

`default_nettype wire

// *** tb/tsp_host.sv ***
// Purpose: Bus host model for the two-wire sensor port
// Assumes: sda has a pull-up; the host only ever pulls it low
// Notes: scl stands high between frames and runs at 80 ns within them
`timescale 1ns/1ns
`default_nettype none

module tsp_host
(
  // Link
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Idle bus: both lines released
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Start or repeated start, sda falls while scl is high
  task automatic start();
    sda_pull = 1'b0;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b1;
    #20 scl = 1'b0;
    #20;
  endtask

  // Stop, then scl stands still
  task automatic stop();
    sda_pull = 1'b1;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b0;
    #40;
  endtask

  // Byte out, data changes only while scl is low
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull = ~b[i];
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
    end
    sda_pull = 1'b0;
    #20 scl = 1'b1;
    #20 ack = ~sda;
    #20 scl = 1'b0;
    #20;
  endtask

  // Byte in; ack asks for more, nack ends the read
  task automatic recv(output logic [7:0] b, input logic ack_it);
    sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #40 scl = 1'b1;
      #20 b[i] = sda;
      #20 scl = 1'b0;
    end
    #20 sda_pull = ack_it;
    #20 scl = 1'b1;
    #40 scl = 1'b0;
    #20 sda_pull = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench of the thermal sensor register port
// Assumes: Host model owns scl; sda resolved here with a pull-up
// Notes: Identity values are arbitrary parameters
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam logic [15:0] PART_ID = 16'ha5c3; // Arbitrary value
  localparam logic [15:0] MAKER_ID = 16'h0e71; // Arbitrary value
  logic ref_clk, sys_rst, sda_out, sda_oe, scl, sda_pull;
  logic alert_req, sample_done, sleep, alert, ack;
  logic [2:0] sa;
  logic [1:0] hyst;
  logic [15:0] temp, res_word, w, wv;
  logic [7:0] b;
  // Second port with the release policy, on a bus of its own
  logic scl2, sda_pull2, sda_oe2, sda_out2, sleep2, alert2;
  logic [3:0] a2;
  wire sda2 = ~(sda_pull2 | (sda_oe2 & ~sda_out2));
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] cw [7] = '{16'hf800, 16'h0600, 16'h0640, 16'h0240,
    16'h0080, 16'h0000, 16'h0200};
  logic [15:0] ce [7] = '{16'h0000, 16'h0600, 16'h0640, 16'h0640,
    16'h0680, 16'h0600, 16'h0200};
  logic [7:0] rw_idx [4] = '{8'h02, 8'h03, 8'h04, 8'h08};
  // Open drain wire, pulled up when nobody drives
  wire sda = ~(sda_pull | (sda_oe & ~sda_out));

  tsp_host host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  tsp_port #(.MAKER_CODE(MAKER_ID), .PART_REV(PART_ID)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_bit_high(sa[2]),
    .strap_bit_mid(sa[1]), .strap_bit_low(sa[0]),
    .measured_temp_in(temp), .alert_request(alert_req),
    .sample_done(sample_done), .sleep_control(sleep),
    .hyst_select(hyst), .resolution_word(res_word),
    .alert_active(alert));

  tsp_host host2 (.scl(scl2), .sda_pull(sda_pull2), .sda(sda2));

  tsp_port #(.CAP_WORD(16'h00cf)) dut2 (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl(scl2), .sda_in(sda2),
    .sda_out(sda_out2), .sda_oe(sda_oe2), .strap_bit_high(1'b0),
    .strap_bit_mid(1'b0), .strap_bit_low(1'b0),
    .measured_temp_in(temp), .alert_request(alert_req),
    .sample_done(sample_done), .sleep_control(sleep2),
    .hyst_select(), .resolution_word(),
    .alert_active(alert2));

  // Sensor clock, 40 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", name, e, g);
      errors++;
    end
  endtask

  // Address, pointer and a whole word, all acknowledged
  task automatic reg_wr(input logic [7:0] idx, input logic [15:0] d);
    logic [3:0] a;
    host.start();
    host.send({4'h3, sa, 1'b0}, a[3]);
    host.send(idx, a[2]);
    host.send(d[15:8], a[1]);
    host.send(d[7:0], a[0]);
    host.stop();
    chk("write acks", 16'h000f, {12'h0, a});
  endtask

  // Word read, optionally setting the pointer first
  task automatic reg_rd(input logic set_ptr, input logic [7:0] idx,
    output logic [15:0] d);
    logic [2:0] a;
    a = 3'b111;
    host.start();
    if (set_ptr)
    begin
      host.send({4'h3, sa, 1'b0}, a[2]);
      host.send(idx, a[1]);
      host.start();
    end
    host.send({4'h3, sa, 1'b1}, a[0]);
    host.recv(d[15:8], 1'b1);
    host.recv(d[7:0], 1'b0);
    host.stop();
    chk("read acks", 16'h0007, {13'h0, a});
  endtask

  task automatic probe(input logic [7:0] addr);
    host.start();
    host.send(addr, ack);
    host.stop();
    chk("foreign ack", 16'h0000, {15'h0, ack});
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    sa = 3'b000;
    temp = 16'h0000;
    alert_req = 1'b0;
    sample_done = 1'b0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("res_word", 16'h000f, res_word);
    chk("sleep hyst", 16'h0000, {13'h0, sleep, hyst});
    reg_rd(1'b0, 8'h00, w);
    chk("cap", 16'h004f, w & 16'hffdf);
    $display("test reset done");
    for (int s = 0; s < 8; s++)
    begin
      @(posedge ref_clk) sa <= s[2:0];
      probe({4'h3, ~s[2:0], 1'b0});
      probe({4'h2, s[2:0], 1'b0});
      probe({4'hb, s[2:0], 1'b0});
      reg_rd(1'b1, 8'h07, w);
      chk("part", PART_ID, w);
    end
    $display("test address done");
    for (int i = 0; i < 7; i++)
    begin
      reg_wr(8'h01, cw[i]);
      repeat (6) @(posedge ref_clk);
      chk("hyst", {14'h0, ce[i][10:9]}, {14'h0, hyst});
      reg_rd(1'b1, 8'h01, w);
      chk("control", ce[i], w);
    end
    $display("test control done");
    reg_wr(8'h00, 16'hffff);
    reg_rd(1'b1, 8'h00, w);
    chk("cap ro", 16'h004f, w & 16'hffdf);
    reg_wr(8'h07, 16'h0000);
    reg_rd(1'b1, 8'h07, w);
    chk("part ro", PART_ID, w);
    for (int i = 0; i < 4; i++)
    begin
      wv = (i == 3) ? 16'h0003 : {4'h0, rw_idx[i][3:0], 8'h54};
      reg_wr(rw_idx[i], wv);
      reg_rd(1'b0, 8'h00, w);
      chk("rw word", wv, w);
    end
    chk("res_word", 16'h0003, res_word);
    host.start();
    host.send({4'h3, sa, 1'b0}, ack);
    host.send(8'h02, ack);
    host.stop();
    reg_rd(1'b0, 8'h00, w);
    chk("ptr only", 16'h0254, w);
    host.start();
    host.send({4'h3, sa, 1'b1}, ack);
    host.recv(b, 1'b1);
    host.recv(b, 1'b1);
    host.recv(b, 1'b0);
    host.stop();
    chk("third byte", 16'h0002, {8'h0, b});
    $display("test registers done");
    @(posedge ref_clk) temp <= 16'h0c8a;
    reg_rd(1'b1, 8'h05, w);
    reg_rd(1'b0, 8'h05, w);
    chk("temp", 16'h0c8a, w);
    @(posedge ref_clk) alert_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("alert on", 16'h0001, {15'h0, alert});
    // Release policy: shutdown drops the alert even while it is wanted
    host2.start();
    host2.send(8'h30, a2[3]);
    host2.send(8'h01, a2[2]);
    host2.send(8'h01, a2[1]);
    host2.send(8'h01, a2[0]);
    host2.stop();
    repeat (6) @(posedge ref_clk);
    chk("policy acks", 16'h000f, {12'h0, a2});
    chk("policy sleep", 16'h0001, {15'h0, sleep2});
    chk("alert released", 16'h0000, {15'h0, alert2});
    reg_wr(8'h01, 16'h0101);
    repeat (6) @(posedge ref_clk);
    chk("sleep", 16'h0001, {15'h0, sleep});
    alert_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("alert frozen", 16'h0001, {15'h0, alert});
    reg_wr(8'h01, 16'h0001);
    repeat (6) @(posedge ref_clk);
    chk("awake", 16'h0000, {15'h0, sleep});
    chk("alert held", 16'h0001, {15'h0, alert});
    @(posedge ref_clk) sample_done <= 1'b1;
    @(posedge ref_clk) sample_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("alert after sample", 16'h0000, {15'h0, alert});
    $display("test sensor done");
    report_and_stop();
  end
endmodule

`default_nettype wire
